// ===== common/lcd_map_pkg.sv
// Shared constants, types and state layouts for the panel output mapper
package lcd_map_pkg;

  // ----------------------------------------
  // Panel bus widths
  // ----------------------------------------
  typedef enum logic [1:0] {
    PANEL_W24 = 2'h0,
    PANEL_W18 = 2'h1,
    PANEL_W16 = 2'h2,
    PANEL_W12 = 2'h3
  } panel_width_e;

  localparam int unsigned PIN_COUNT = 24;
  localparam logic [23:0] PINS_RESET = 24'h00_0000;

  // Pin field positions, low bit of the red and green fields (blue always starts at pin 0)
  localparam int unsigned W24_RED_LSB   = 16;
  localparam int unsigned W24_GREEN_LSB = 8;
  localparam int unsigned W18_RED_LSB   = 12;
  localparam int unsigned W18_GREEN_LSB = 6;
  localparam int unsigned W16_RED_LSB   = 11;
  localparam int unsigned W16_GREEN_LSB = 5;
  localparam int unsigned W12_RED_LSB   = 8;
  localparam int unsigned W12_GREEN_LSB = 4;

  // ----------------------------------------
  // Layer layouts seen by the fetch engine
  // ----------------------------------------
  typedef enum logic [3:0] {
    FMT_RGB_LOW       = 4'h0,  // 12 and 16 bpp
    FMT_RGB_PACKED    = 4'h1,  // packed 18, 19, 24 bpp
    FMT_RGB_UNPACKED  = 4'h2,  // unpacked 18 to 32 bpp
    FMT_YUV_ALPHA     = 4'h3,  // alpha_luma_chroma_packed, 32 bpp
    FMT_YUV422_PACKED = 4'h4,
    FMT_YUV422_SEMI   = 4'h5,
    FMT_YUV422_PLANAR = 4'h6,
    FMT_YUV420_SEMI   = 4'h7,
    FMT_YUV420_PLANAR = 4'h8
  } fetch_fmt_e;

  // Rates in thousandths of a pixel per cycle
  localparam logic [12:0] CREDIT_UNIT    = 13'h03e8;
  localparam logic [12:0] RATE_2P        = 13'h07d0;
  localparam logic [12:0] RATE_1P333     = 13'h0535;
  localparam logic [12:0] RATE_1P        = 13'h03e8;
  localparam logic [12:0] RATE_2P66      = 13'h0a64;
  localparam logic [12:0] RATE_4P        = 13'h0fa0;
  localparam logic [12:0] RATE_0P66      = 13'h0294;
  localparam logic [12:0] RATE_0P5       = 13'h01f4;
  localparam logic [12:0] RATE_0P8       = 13'h0320;
  localparam logic [12:0] RATE_0P2       = 13'h00c8;
  localparam logic [12:0] RATE_0P132     = 13'h0084;
  localparam logic [12:0] RATE_0P1       = 13'h0064;
  localparam logic [12:0] RATE_0P16      = 13'h00a0;
  localparam logic [12:0] RATE_NONE      = 13'h0000;
  localparam logic [12:0] CREDIT_RESET   = 13'h0000;

  localparam logic [2:0]  LUMA_BURST     = 3'h4;
  localparam logic [2:0]  LUMA_ROT       = 3'h1;
  localparam logic [2:0]  LUMA_NONE      = 3'h0;
  localparam int unsigned MAX_GRANT      = 4;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;

  // ----------------------------------------
  // Fetch engine state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_FETCH = 2'h2
  } fetch_state_e;

  typedef struct packed {
    fetch_state_e st;
    logic [12:0]  rate;
    logic [12:0]  credit;
    logic [15:0]  remaining;
    logic [2:0]   granted;
    logic [1:0]   streams;
    logic [2:0]   luma;
    logic         lock;
    logic         done;
    logic         refused;
  } fetch_state_s;

  typedef struct packed {
    logic [23:0] pins;
    logic        valid;
  } lane_state_s;

endpackage

// ===== common/pixel_map_if.sv
// Carrier between the top module and the pixel lane mapper
`timescale 1ns/1ps
`default_nettype none
interface pixel_map_if;
  lcd_map_pkg::panel_width_e width;
  logic                      valid;
  logic [7:0]                red;
  logic [7:0]                green;
  logic [7:0]                blue;
  logic [23:0]               pins;
  logic                      pins_valid;

  modport source (
    output width,
    output valid,
    output red,
    output green,
    output blue,
    input  pins,
    input  pins_valid
  );

  modport mapper (
    input  width,
    input  valid,
    input  red,
    input  green,
    input  blue,
    output pins,
    output pins_valid
  );
endinterface
`default_nettype wire

// ===== logic/pixel_lane_mapper.sv
// Places one RGB pixel onto the 24 panel data pins for the chosen panel width
`timescale 1ns/1ps
`default_nettype none
module pixel_lane_mapper (
  input  wire logic    mclk,
  input  wire logic    reset,
  pixel_map_if.mapper  m
);

  lcd_map_pkg::lane_state_s q;
  lcd_map_pkg::lane_state_s d;

  function automatic logic [23:0] map_pixel(
    input lcd_map_pkg::panel_width_e w,
    input logic [7:0]                r,
    input logic [7:0]                g,
    input logic [7:0]                b
  );
    logic [23:0] p;
    p = lcd_map_pkg::PINS_RESET;
    case (w)
      lcd_map_pkg::PANEL_W24: begin
        p[lcd_map_pkg::W24_RED_LSB +: 8]   = r;
        p[lcd_map_pkg::W24_GREEN_LSB +: 8] = g;
        p[7:0]                             = b;
      end
      lcd_map_pkg::PANEL_W18: begin
        p[lcd_map_pkg::W18_RED_LSB +: 6]   = r[5:0];
        p[lcd_map_pkg::W18_GREEN_LSB +: 6] = g[5:0];
        p[5:0]                             = b[5:0];
      end
      lcd_map_pkg::PANEL_W16: begin
        p[lcd_map_pkg::W16_RED_LSB +: 5]   = r[4:0];
        p[lcd_map_pkg::W16_GREEN_LSB +: 6] = g[5:0];
        p[4:0]                             = b[4:0];
      end
      lcd_map_pkg::PANEL_W12: begin
        p[lcd_map_pkg::W12_RED_LSB +: 4]   = r[3:0];
        p[lcd_map_pkg::W12_GREEN_LSB +: 4] = g[3:0];
        p[3:0]                             = b[3:0];
      end
      default: begin
        p = lcd_map_pkg::PINS_RESET;
      end
    endcase
    return p;
  endfunction

  always_comb begin
    d       = q;
    d.valid = m.valid;
    // Pins hold the last pixel between strobes so the panel sees stable data
    if (m.valid) begin
      d.pins = map_pixel(m.width, m.red, m.green, m.blue);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q.pins  <= lcd_map_pkg::PINS_RESET;
      q.valid <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign m.pins       = q.pins;
  assign m.pins_valid = q.valid;

endmodule
`default_nettype wire

// ===== logic/lcd_pixel_output_mapper.sv
// Panel pixel output mapper with layer fetch throughput pacing
`timescale 1ns/1ps
`default_nettype none

module lcd_pixel_output_mapper (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire lcd_map_pkg::panel_width_e panel_width,
  input  wire logic                      pixel_valid,
  input  wire logic [7:0]                pixel_red,
  input  wire logic [7:0]                pixel_green,
  input  wire logic [7:0]                pixel_blue,
  output logic [23:0]                    panel_pixel_pins,
  output logic                           panel_data_valid,
  input  wire lcd_map_pkg::fetch_fmt_e   fetch_format,
  input  wire logic                      rotate_en,
  input  wire logic                      rotate_opt,
  input  wire logic                      dual_bus,
  input  wire logic                      line_start,
  input  wire logic [15:0]               line_pixels,
  output logic                           fetch_busy,
  output logic                           bus_lock,
  output logic [2:0]                     pixels_granted,
  output logic [1:0]                     stream_count,
  output logic [2:0]                     luma_per_cycle,
  output logic                           line_done,
  output logic                           line_refused
);

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------
  pixel_map_if px ();

  assign px.width = panel_width;
  assign px.valid = pixel_valid;
  assign px.red   = pixel_red;
  assign px.green = pixel_green;
  assign px.blue  = pixel_blue;

  pixel_lane_mapper u_lanes (
    .mclk  (mclk),
    .reset (reset),
    .m     (px.mapper)
  );

  assign panel_pixel_pins = px.pins;
  assign panel_data_valid = px.pins_valid;

  // ----------------------------------------
  // Fetch rate table
  // ----------------------------------------
  // Returns the sustained rate; RATE_NONE marks a combination with no support.
  function automatic logic [12:0] fetch_rate(
    input lcd_map_pkg::fetch_fmt_e f,
    input logic                    rot,
    input logic                    opt,
    input logic                    dual
  );
    logic [12:0] r;
    r = lcd_map_pkg::RATE_NONE;
    case (f)
      lcd_map_pkg::FMT_RGB_LOW: begin
        r = !rot ? lcd_map_pkg::RATE_2P
          : (opt ? lcd_map_pkg::RATE_1P : lcd_map_pkg::RATE_0P2);
      end
      lcd_map_pkg::FMT_RGB_PACKED: begin
        r = !rot ? lcd_map_pkg::RATE_1P333
          : (opt ? lcd_map_pkg::RATE_NONE : lcd_map_pkg::RATE_0P2);
      end
      lcd_map_pkg::FMT_RGB_UNPACKED, lcd_map_pkg::FMT_YUV_ALPHA: begin
        r = !rot ? lcd_map_pkg::RATE_1P
          : (opt ? lcd_map_pkg::RATE_1P : lcd_map_pkg::RATE_0P2);
      end
      lcd_map_pkg::FMT_YUV422_PACKED: begin
        r = !rot ? lcd_map_pkg::RATE_2P : lcd_map_pkg::RATE_NONE;
      end
      lcd_map_pkg::FMT_YUV422_SEMI: begin
        if (dual) begin
          r = !rot ? lcd_map_pkg::RATE_4P
            : (opt ? lcd_map_pkg::RATE_1P : lcd_map_pkg::RATE_0P2);
        end else begin
          r = !rot ? lcd_map_pkg::RATE_2P
            : (opt ? lcd_map_pkg::RATE_0P66 : lcd_map_pkg::RATE_0P132);
        end
      end
      lcd_map_pkg::FMT_YUV422_PLANAR: begin
        if (dual) begin
          r = !rot ? lcd_map_pkg::RATE_4P
            : (opt ? lcd_map_pkg::RATE_1P : lcd_map_pkg::RATE_0P2);
        end else begin
          r = !rot ? lcd_map_pkg::RATE_2P
            : (opt ? lcd_map_pkg::RATE_0P5 : lcd_map_pkg::RATE_0P1);
        end
      end
      lcd_map_pkg::FMT_YUV420_SEMI: begin
        if (dual) begin
          r = !rot ? lcd_map_pkg::RATE_4P
            : (opt ? lcd_map_pkg::RATE_1P : lcd_map_pkg::RATE_0P2);
        end else begin
          r = !rot ? lcd_map_pkg::RATE_2P66
            : (opt ? lcd_map_pkg::RATE_0P8 : lcd_map_pkg::RATE_0P16);
        end
      end
      lcd_map_pkg::FMT_YUV420_PLANAR: begin
        if (dual) begin
          r = !rot ? lcd_map_pkg::RATE_4P
            : (opt ? lcd_map_pkg::RATE_1P : lcd_map_pkg::RATE_0P2);
        end else begin
          r = !rot ? lcd_map_pkg::RATE_2P66
            : (opt ? lcd_map_pkg::RATE_0P66 : lcd_map_pkg::RATE_0P132);
        end
      end
      default: begin
        r = lcd_map_pkg::RATE_NONE;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Stream layout per format
  // ----------------------------------------
  function automatic logic [1:0] stream_of(input lcd_map_pkg::fetch_fmt_e f);
    logic [1:0] s;
    case (f)
      lcd_map_pkg::FMT_YUV422_SEMI, lcd_map_pkg::FMT_YUV420_SEMI: begin
        s = 2'h2;
      end
      lcd_map_pkg::FMT_YUV422_PLANAR, lcd_map_pkg::FMT_YUV420_PLANAR: begin
        s = 2'h3;
      end
      default: begin
        s = 2'h1;
      end
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // Fetch engine
  // ----------------------------------------
  lcd_map_pkg::fetch_state_s q;
  lcd_map_pkg::fetch_state_s d;

  always_comb begin
    logic [12:0] rate_v;
    logic [12:0] credit_v;
    logic [15:0] rem_v;
    logic [2:0]  grant_v;
    rate_v    = fetch_rate(fetch_format, rotate_en, rotate_opt, dual_bus);
    credit_v  = q.credit;
    rem_v     = q.remaining;
    grant_v   = 3'h0;
    d         = q;
    d.granted = 3'h0;
    d.done    = 1'b0;
    d.refused = 1'b0;
    case (q.st)
      lcd_map_pkg::ST_IDLE: begin
        if (line_start) begin
          // Unsupported layout/rotation pairs are refused, not run slowly
          if (rate_v == lcd_map_pkg::RATE_NONE || line_pixels == lcd_map_pkg::COUNT_RESET) begin
            d.refused = 1'b1;
          end else begin
            d.st        = lcd_map_pkg::ST_FETCH;
            d.rate      = rate_v;
            d.credit    = lcd_map_pkg::CREDIT_RESET;
            d.remaining = line_pixels;
            d.streams   = stream_of(fetch_format);
            d.luma      = (d.streams == 2'h1) ? lcd_map_pkg::LUMA_NONE
                        : (!rotate_en ? lcd_map_pkg::LUMA_BURST
                        : lcd_map_pkg::LUMA_ROT);
            d.lock      = rotate_en && rotate_opt;
          end
        end
      end
      lcd_map_pkg::ST_FETCH: begin
        credit_v = q.credit + q.rate;
        for (int i = 0; i < lcd_map_pkg::MAX_GRANT; i++) begin
          if (credit_v >= lcd_map_pkg::CREDIT_UNIT && rem_v != lcd_map_pkg::COUNT_RESET) begin
            credit_v = credit_v - lcd_map_pkg::CREDIT_UNIT;
            rem_v    = rem_v - 16'h0001;
            grant_v  = grant_v + 3'h1;
          end
        end
        d.credit    = credit_v;
        d.remaining = rem_v;
        d.granted   = grant_v;
        if (rem_v == lcd_map_pkg::COUNT_RESET) begin
          // Lock is released together with the last beat of the line
          d.st   = lcd_map_pkg::ST_IDLE;
          d.done = 1'b1;
          d.lock = 1'b0;
        end
      end
      default: begin
        d.st   = lcd_map_pkg::ST_IDLE;
        d.lock = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q.st        <= lcd_map_pkg::ST_IDLE;
      q.rate      <= lcd_map_pkg::RATE_NONE;
      q.credit    <= lcd_map_pkg::CREDIT_RESET;
      q.remaining <= lcd_map_pkg::COUNT_RESET;
      q.granted   <= 3'h0;
      q.streams   <= 2'h0;
      q.luma      <= lcd_map_pkg::LUMA_NONE;
      q.lock      <= 1'b0;
      q.done      <= 1'b0;
      q.refused   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign fetch_busy     = (q.st == lcd_map_pkg::ST_FETCH);
  assign bus_lock       = q.lock;
  assign pixels_granted = q.granted;
  assign stream_count   = q.streams;
  assign luma_per_cycle = q.luma;
  assign line_done      = q.done;
  assign line_refused   = q.refused;

endmodule
`default_nettype wire

// ===== bench/lcd_pixel_output_mapper_props.sv
// Port-level checker for the panel output mapper
`timescale 1ns/1ps
`default_nettype none
module lcd_pixel_output_mapper_props (
  input wire logic                      mclk,
  input wire logic                      reset,
  input wire lcd_map_pkg::panel_width_e panel_width,
  input wire logic                      pixel_valid,
  input wire logic [7:0]                pixel_red,
  input wire logic [7:0]                pixel_green,
  input wire logic [7:0]                pixel_blue,
  input wire logic [23:0]               panel_pixel_pins,
  input wire logic                      panel_data_valid,
  input wire lcd_map_pkg::fetch_fmt_e   fetch_format,
  input wire logic                      rotate_en,
  input wire logic                      rotate_opt,
  input wire logic                      dual_bus,
  input wire logic                      line_start,
  input wire logic [15:0]               line_pixels,
  input wire logic                      fetch_busy,
  input wire logic                      bus_lock,
  input wire logic [1:0]                stream_count,
  input wire logic [2:0]                luma_per_cycle,
  input wire logic                      line_done,
  input wire logic                      line_refused
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic go = line_start && !fetch_busy;

  property p_w24;
    pixel_valid && panel_width == lcd_map_pkg::PANEL_W24 |=> panel_data_valid &&
      panel_pixel_pins == {$past(pixel_red), $past(pixel_green), $past(pixel_blue)};
  endproperty
  a_w24: assert property (p_w24) else $error("24-bit pin map wrong");
  property p_w18;
    pixel_valid && panel_width == lcd_map_pkg::PANEL_W18 |=> panel_pixel_pins ==
      {6'h0, $past(pixel_red[5:0]), $past(pixel_green[5:0]), $past(pixel_blue[5:0])};
  endproperty
  a_w18: assert property (p_w18) else $error("18-bit pin map wrong");
  property p_w16;
    pixel_valid && panel_width == lcd_map_pkg::PANEL_W16 |=> panel_pixel_pins ==
      {8'h00, $past(pixel_red[4:0]), $past(pixel_green[5:0]), $past(pixel_blue[4:0])};
  endproperty
  a_w16: assert property (p_w16) else $error("16-bit pin map wrong");
  property p_w12;
    pixel_valid && panel_width == lcd_map_pkg::PANEL_W12 |=> panel_pixel_pins ==
      {12'h000, $past(pixel_red[3:0]), $past(pixel_green[3:0]), $past(pixel_blue[3:0])};
  endproperty
  a_w12: assert property (p_w12) else $error("12-bit pin map wrong");
  property p_lock;
    go && rotate_en && rotate_opt && fetch_format == lcd_map_pkg::FMT_RGB_UNPACKED &&
      line_pixels != 16'h0000 |=> bus_lock && fetch_busy;
  endproperty
  a_lock: assert property (p_lock) else $error("bus lock missing");
  property p_lock_busy;
    bus_lock |-> fetch_busy;
  endproperty
  a_lock_busy: assert property (p_lock_busy) else $error("lock outside a line");
  property p_packed_ref;
    go && rotate_en && rotate_opt && fetch_format == lcd_map_pkg::FMT_RGB_PACKED
      |=> line_refused && !fetch_busy;
  endproperty
  a_packed_ref: assert property (p_packed_ref) else $error("packed rotation taken");
  property p_burst_low;
    go && !rotate_en && fetch_format == lcd_map_pkg::FMT_RGB_LOW && line_pixels == 16'h0004
      |-> ##3 line_done;
  endproperty
  a_burst_low: assert property (p_burst_low) else $error("2 px rate missed");
  property p_yuv_packed;
    go && rotate_en && fetch_format == lcd_map_pkg::FMT_YUV422_PACKED |=> line_refused;
  endproperty
  a_yuv_packed: assert property (p_yuv_packed) else $error("packed yuv rotation taken");
  property p_semi;
    go && !rotate_en && line_pixels != 16'h0000 &&
      (fetch_format == lcd_map_pkg::FMT_YUV422_SEMI ||
      fetch_format == lcd_map_pkg::FMT_YUV420_SEMI) |=> stream_count == 2'h2 &&
      luma_per_cycle == 3'h4;
  endproperty
  a_semi: assert property (p_semi) else $error("semiplanar streams wrong");
  property p_420_one;
    go && !rotate_en && !dual_bus && fetch_format == lcd_map_pkg::FMT_YUV420_SEMI &&
      line_pixels == 16'h0008 |-> ##5 line_done;
  endproperty
  a_420_one: assert property (p_420_one) else $error("2.66 px rate missed");
  property p_dual;
    go && !rotate_en && dual_bus && fetch_format == lcd_map_pkg::FMT_YUV420_PLANAR &&
      line_pixels == 16'h0008 |-> ##3 line_done;
  endproperty
  a_dual: assert property (p_dual) else $error("4 px rate missed");
endmodule

bind lcd_pixel_output_mapper lcd_pixel_output_mapper_props i_lcd_pixel_output_mapper_props (
  .mclk(mclk), .reset(reset), .panel_width(panel_width), .pixel_valid(pixel_valid),
  .pixel_red(pixel_red), .pixel_green(pixel_green), .pixel_blue(pixel_blue),
  .panel_pixel_pins(panel_pixel_pins), .panel_data_valid(panel_data_valid),
  .fetch_format(fetch_format), .rotate_en(rotate_en), .rotate_opt(rotate_opt),
  .dual_bus(dual_bus), .line_start(line_start), .line_pixels(line_pixels),
  .fetch_busy(fetch_busy), .bus_lock(bus_lock), .stream_count(stream_count),
  .luma_per_cycle(luma_per_cycle), .line_done(line_done), .line_refused(line_refused)
);
`default_nettype wire

// ===== bench/tft_panel_model.sv
// Parallel RGB panel that latches the data pins on each valid strobe
`timescale 1ns/1ps
`default_nettype none
module tft_panel_model (
  input  wire logic        mclk,
  input  wire logic [23:0] panel_pixel_pins,
  input  wire logic        panel_data_valid,
  output logic [23:0]      shown_pixel
);
  initial shown_pixel = 24'h00_0000;
  always @(posedge mclk) begin
    if (panel_data_valid === 1'b1) begin
      shown_pixel <= panel_pixel_pins;
    end
  end
endmodule
`default_nettype wire

// ===== bench/lcd_pixel_output_mapper_tb_top.sv
// Self-checking bench for the panel output mapper
`timescale 1ns/1ps
`default_nettype none
module lcd_pixel_output_mapper_tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  lcd_map_pkg::panel_width_e panel_width = lcd_map_pkg::PANEL_W24;
  lcd_map_pkg::fetch_fmt_e   fetch_format = lcd_map_pkg::FMT_RGB_LOW;
  logic pixel_valid = 1'b0, rotate_en = 1'b0, rotate_opt = 1'b0, dual_bus = 1'b0;
  logic line_start = 1'b0;
  logic [7:0]  pixel_red = 8'h00, pixel_green = 8'h00, pixel_blue = 8'h00;
  logic [15:0] line_pixels = 16'h0000;
  logic [23:0] panel_pixel_pins, shown_pixel;
  logic panel_data_valid, fetch_busy, bus_lock, line_done, line_refused;
  logic [2:0] pixels_granted, luma_per_cycle;
  logic [1:0] stream_count;
  int err_count = 0, tests_run = 0, cycles = 0;
  localparam logic [7:0] RC = 8'hc9, GC = 8'h6e, BC = 8'hb3;

  always #50 mclk = ~mclk;

  lcd_pixel_output_mapper i_lcd_pixel_output_mapper (
    .mclk(mclk), .reset(reset), .panel_width(panel_width), .pixel_valid(pixel_valid),
    .pixel_red(pixel_red), .pixel_green(pixel_green), .pixel_blue(pixel_blue),
    .panel_pixel_pins(panel_pixel_pins), .panel_data_valid(panel_data_valid),
    .fetch_format(fetch_format), .rotate_en(rotate_en), .rotate_opt(rotate_opt),
    .dual_bus(dual_bus), .line_start(line_start), .line_pixels(line_pixels),
    .fetch_busy(fetch_busy), .bus_lock(bus_lock), .pixels_granted(pixels_granted),
    .stream_count(stream_count), .luma_per_cycle(luma_per_cycle), .line_done(line_done),
    .line_refused(line_refused)
  );
  tft_panel_model i_tft_panel_model (
    .mclk(mclk), .panel_pixel_pins(panel_pixel_pins), .panel_data_valid(panel_data_valid),
    .shown_pixel(shown_pixel)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Stale upper pins from the previous wider pixel must be cleared
  task automatic pixel_case(input lcd_map_pkg::panel_width_e w, input logic [23:0] exp);
    @(posedge mclk);
    panel_width <= w;
    pixel_red <= RC;
    pixel_green <= GC;
    pixel_blue <= BC;
    pixel_valid <= 1'b1;
    @(posedge mclk);
    pixel_valid <= 1'b0;
    #1 check("data valid", panel_data_valid, 1);
    @(posedge mclk);
    #1 check("panel pixel", shown_pixel, exp);
    $display("pixel width %0d done", w);
  endtask

  // Rate in thousandths of a pixel per cycle; zero means a refusal is expected
  task automatic run_line(input lcd_map_pkg::fetch_fmt_e f, input logic rot, input logic opt,
                          input logic dual, input logic [15:0] n, input int rate,
                          input logic [1:0] strs, input logic [2:0] luma);
    int cyc;
    logic [31:0] sum;
    cyc = 0;
    sum = 0;
    @(posedge mclk);
    fetch_format <= f;
    rotate_en <= rot;
    rotate_opt <= opt;
    dual_bus <= dual;
    line_pixels <= n;
    line_start <= 1'b1;
    @(posedge mclk);
    line_start <= 1'b0;
    #1;
    if (rate == 0) begin
      check("refused", {line_refused, fetch_busy}, 2'b10);
    end else begin
      check("lock", {fetch_busy, bus_lock}, {1'b1, rot & opt});
      check("streams", {stream_count, luma_per_cycle}, {strs, luma});
      while (cyc < 2000) begin
        @(posedge mclk);
        #1;
        cyc++;
        sum = sum + pixels_granted;
        if (line_done === 1'b1) break;
      end
      check("line cycles", cyc, (n * 1000 + rate - 1) / rate);
      check("pixels granted", sum, n);
    end
    $display("line format %0d done", f);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    pixel_case(lcd_map_pkg::PANEL_W24, {RC, GC, BC});
    pixel_case(lcd_map_pkg::PANEL_W18, {6'h0, RC[5:0], GC[5:0], BC[5:0]});
    pixel_case(lcd_map_pkg::PANEL_W16, {8'h0, RC[4:0], GC[5:0], BC[4:0]});
    pixel_case(lcd_map_pkg::PANEL_W12, {12'h0, RC[3:0], GC[3:0], BC[3:0]});
    run_line(lcd_map_pkg::FMT_RGB_LOW, 0, 0, 0, 16'h0004, 2000, 2'h1, 3'h0);
    run_line(lcd_map_pkg::FMT_RGB_PACKED, 0, 0, 0, 16'h0004, 1333, 2'h1, 3'h0);
    run_line(lcd_map_pkg::FMT_RGB_UNPACKED, 1, 1, 0, 16'h0003, 1000, 2'h1, 3'h0);
    run_line(lcd_map_pkg::FMT_RGB_PACKED, 1, 1, 0, 16'h0003, 0, 2'h0, 3'h0);
    run_line(lcd_map_pkg::FMT_RGB_LOW, 1, 0, 0, 16'h0002, 200, 2'h1, 3'h0);
    run_line(lcd_map_pkg::FMT_YUV_ALPHA, 0, 0, 0, 16'h0003, 1000, 2'h1, 3'h0);
    run_line(lcd_map_pkg::FMT_YUV422_PACKED, 0, 0, 0, 16'h0004, 2000, 2'h1, 3'h0);
    run_line(lcd_map_pkg::FMT_YUV422_PACKED, 1, 0, 0, 16'h0004, 0, 2'h0, 3'h0);
    run_line(lcd_map_pkg::FMT_YUV422_SEMI, 0, 0, 0, 16'h0004, 2000, 2'h2, 3'h4);
    run_line(lcd_map_pkg::FMT_YUV420_SEMI, 0, 0, 0, 16'h0008, 2660, 2'h2, 3'h4);
    run_line(lcd_map_pkg::FMT_YUV422_PLANAR, 1, 1, 0, 16'h0002, 500, 2'h3, 3'h1);
    run_line(lcd_map_pkg::FMT_YUV420_PLANAR, 0, 0, 1, 16'h0008, 4000, 2'h3, 3'h4);
    run_line(lcd_map_pkg::FMT_YUV420_SEMI, 1, 0, 1, 16'h0001, 200, 2'h2, 3'h1);
    run_line(lcd_map_pkg::FMT_YUV420_PLANAR, 1, 1, 1, 16'h0002, 1000, 2'h3, 3'h1);
    run_line(lcd_map_pkg::FMT_YUV420_SEMI, 1, 1, 0, 16'h0004, 800, 2'h2, 3'h1);
    run_line(lcd_map_pkg::FMT_YUV422_SEMI, 1, 0, 0, 16'h0001, 132, 2'h2, 3'h1);
    run_line(lcd_map_pkg::FMT_YUV422_PLANAR, 1, 0, 0, 16'h0001, 100, 2'h3, 3'h1);
    run_line(lcd_map_pkg::FMT_RGB_LOW, 0, 0, 0, 16'h0000, 0, 2'h0, 3'h0);
    finish_test();
  end
endmodule
`default_nettype wire
